// ### common/lgsd_defs.svh
/*
  Constants for the LED grayscale serial driver: channel counts, field widths,
  serial frame lengths and the PWM period.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef LGSD_DEFS_SVH
`define LGSD_DEFS_SVH

`define LGSD_NUM_CH     16
`define LGSD_GS_W       12
`define LGSD_DC_W       6
`define LGSD_GS_BITS    192
`define LGSD_DC_BITS    96
`define LGSD_CNT_W      13
`define LGSD_PWM_PERIOD 13'h1000
`define LGSD_PROD_W     18
`define LGSD_SYNC_RST   6'h00

`endif

// ### common/lgsd_pkg.sv
/*
  Types for the LED grayscale serial driver.
  Assumes lgsd_defs.svh is on the include path.
*/
`include "lgsd_defs.svh"

package lgsd_pkg;

  // one sample of every pin coming from the host
  typedef struct packed {
    logic serial_data_in;
    logic shift_clk;
    logic latch_strobe;
    logic grayscale_clock;
    logic blank;
    logic load_dc;
  } lgsd_link_t;

  typedef logic [`LGSD_GS_BITS-1:0] lgsd_shreg_t;
  typedef logic [`LGSD_DC_BITS-1:0] lgsd_dcreg_t;
  typedef logic [`LGSD_CNT_W-1:0]   lgsd_cnt_t;

endpackage : lgsd_pkg

// ### src/lgsd_top.sv
/*
  LED grayscale serial driver: serial input shift register, grayscale and
  dot-correction holding registers, and a 16-channel PWM stage.
  All host pins pass a two-stage synchroniser; edges are found one stage later.
  The PWM counter saturates at the end of the period and waits for blanking,
  so a late blanking pulse leaves the outputs dark rather than wrapping.
  Assumes all host pins are asynchronous to i_clk and that the host's shift
  clock and grayscale clock are well below a quarter of i_clk.
*/
`timescale 1ns/1ps
`include "lgsd_defs.svh"

module lgsd_top
  import lgsd_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst_n,
  input  wire logic                    i_serial_data_in,
  input  wire logic                    i_shift_clk,
  input  wire logic                    i_latch_strobe,
  input  wire logic                    i_grayscale_clock,
  input  wire logic                    i_blank,
  input  wire logic                    i_load_dc,
  output logic      [`LGSD_NUM_CH-1:0] o_led,
  output logic                         o_serial_data_out
);

  lgsd_link_t                    meta_q;
  lgsd_link_t                    sync_q;
  lgsd_link_t                    dly_q;
  lgsd_link_t                    pins;
  lgsd_shreg_t                   shreg_q;
  lgsd_shreg_t                   gs_q;
  lgsd_dcreg_t                   dc_q;
  lgsd_cnt_t                     cnt_q;
  logic       [`LGSD_NUM_CH-1:0] on_d;
  logic       [`LGSD_NUM_CH-1:0] led_q;
  logic                          shift_rise;
  logic                          latch_rise;
  logic                          grayscale_clock_rise;

  assign pins = '{serial_data_in:  i_serial_data_in,
                  shift_clk:       i_shift_clk,
                  latch_strobe:    i_latch_strobe,
                  grayscale_clock: i_grayscale_clock,
                  blank:           i_blank,
                  load_dc:         i_load_dc};

  // two-stage synchroniser, then one delay stage for edge finding
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= `LGSD_SYNC_RST;
      sync_q <= `LGSD_SYNC_RST;
      dly_q  <= `LGSD_SYNC_RST;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      dly_q  <= sync_q;
    end
  end

  assign shift_rise = sync_q.shift_clk & ~dly_q.shift_clk;
  assign latch_rise = sync_q.latch_strobe & ~dly_q.latch_strobe;
  assign grayscale_clock_rise = sync_q.grayscale_clock & ~dly_q.grayscale_clock;

  // input shift register, msb side feeds the next device
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shreg_q <= '0;
    end else if (shift_rise) begin
      shreg_q <= {shreg_q[`LGSD_GS_BITS-2:0], sync_q.serial_data_in};
    end
  end

  assign o_serial_data_out = shreg_q[`LGSD_GS_BITS-1];

  // holding registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gs_q <= '0;
      dc_q <= '0;
    end else if (latch_rise) begin
      if (sync_q.load_dc) begin
        dc_q <= shreg_q[`LGSD_DC_BITS-1:0];
      end else begin
        gs_q <= shreg_q;
      end
    end
  end

  // pwm counter, stops at the end of the period until blanked
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else if (sync_q.blank) begin
      cnt_q <= '0;
    end else if (grayscale_clock_rise && cnt_q != `LGSD_PWM_PERIOD) begin
      cnt_q <= cnt_q + `LGSD_CNT_W'(1);
    end
  end

  // per-channel on-time scaled by dot correction
  genvar ch;
  generate
    for (ch = 0; ch < `LGSD_NUM_CH; ch++) begin : g_ch
      logic [`LGSD_GS_W-1:0]   gs;
      logic [`LGSD_DC_W:0]     dc1;
      logic [`LGSD_PROD_W-1:0] prod;
      assign gs      = gs_q[ch*`LGSD_GS_W +: `LGSD_GS_W];
      assign dc1     = {1'b0, dc_q[ch*`LGSD_DC_W +: `LGSD_DC_W]} + 7'h01;
      assign prod    = `LGSD_PROD_W'(gs * dc1);
      assign on_d[ch] = cnt_q < {1'b0, prod[`LGSD_PROD_W-1:`LGSD_DC_W]};
    end
  endgenerate

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      led_q <= '0;
    end else begin
      led_q <= sync_q.blank ? '0 : on_d;
    end
  end

  assign o_led = led_q;

  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  shift_capture_a: assert property (
    shift_rise |=> shreg_q[0] == $past(sync_q.serial_data_in))
    else $error("shift register missed the data bit");

  chain_out_a: assert property (
    shift_rise |=> o_serial_data_out == $past(shreg_q[`LGSD_GS_BITS-2]))
    else $error("chain output did not follow the shift");

  latch_gs_a: assert property (
    latch_rise && !sync_q.load_dc |=> gs_q == $past(shreg_q) && $stable(dc_q))
    else $error("grayscale latch wrong");

  latch_dc_a: assert property (
    latch_rise && sync_q.load_dc |=> dc_q == $past(shreg_q[`LGSD_DC_BITS-1:0]) && $stable(gs_q))
    else $error("dot-correction latch wrong");

  hold_regs_a: assert property (
    !latch_rise |=> $stable(gs_q) && $stable(dc_q))
    else $error("holding register changed without latch");

  cnt_advance_a: assert property (
    grayscale_clock_rise && !sync_q.blank && cnt_q < `LGSD_PWM_PERIOD |=> cnt_q == $past(cnt_q) + 1)
    else $error("pwm counter did not advance");

  blank_cnt_a: assert property (
    sync_q.blank |=> cnt_q == 0)
    else $error("counter not cleared by blanking");

  blank_off_a: assert property (
    sync_q.blank [*2] |=> o_led == '0)
    else $error("outputs on during blanking");

  period_end_a: assert property (
    cnt_q == `LGSD_PWM_PERIOD && !sync_q.blank |=> o_led == '0)
    else $error("output on after pwm period end");

  shreg_hold_a: assert property (
    !shift_rise |=> $stable(shreg_q))
    else $error("shift register moved without a shift clock edge");

  shift_move_a: assert property (
    shift_rise |=> shreg_q[`LGSD_GS_BITS-1:1] == $past(shreg_q[`LGSD_GS_BITS-2:0]))
    else $error("shift register did not move by one place");

  chain_hold_a: assert property (
    !shift_rise |=> $stable(o_serial_data_out))
    else $error("chain output changed without a shift");

  cnt_hold_a: assert property (
    !grayscale_clock_rise && !sync_q.blank |=> $stable(cnt_q))
    else $error("pwm counter moved without a grayscale clock edge");

  cnt_sat_a: assert property (
    cnt_q == `LGSD_PWM_PERIOD && !sync_q.blank |=> cnt_q == `LGSD_PWM_PERIOD)
    else $error("pwm counter left the end of the period without blanking");

  cnt_range_a: assert property (
    cnt_q <= `LGSD_PWM_PERIOD)
    else $error("pwm counter beyond the period");

  blank_release_a: assert property (
    $fell(sync_q.blank) |-> cnt_q == '0)
    else $error("counter not at zero when blanking ended");

  gs_zero_a: assert property (
    gs_q[`LGSD_GS_W-1:0] == '0 |=> !o_led[0])
    else $error("channel with zero grayscale turned on");

  on_limit_a: assert property (
    cnt_q >= {1'b0, gs_q[`LGSD_GS_BITS-1 -: `LGSD_GS_W]} |=> !o_led[`LGSD_NUM_CH-1])
    else $error("channel on beyond its grayscale value");

  dc_load_c:   cover property (latch_rise && sync_q.load_dc);
  gs_load_c:   cover property (latch_rise && !sync_q.load_dc);
  period_c:    cover property (cnt_q == `LGSD_PWM_PERIOD ##[1:20] sync_q.blank);
  led_on_c:    cover property (o_led[0] && !sync_q.blank);
  shift_dc_c:  cover property (shift_rise && sync_q.load_dc);

endmodule : lgsd_top

// ### verification/lgsd_host.sv
/* host model driving the six pins of the driver through tasks
   assumes i_clk at 100 MHz; pin edges land on i_clk rising edges */
`timescale 1ns/1ps
module lgsd_host
  import lgsd_pkg::*;
(
  input  wire logic i_clk,
  output lgsd_link_t o_link
);
  initial o_link = '0;
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  task automatic sclk(input logic d);
    o_link.serial_data_in <= d;
    o_link.shift_clk      <= 1'b0;
    tick(4);
    o_link.shift_clk      <= 1'b1;
    tick(4);
  endtask : sclk
  task automatic load(input logic dc, input logic [15:0] w [16]);
    o_link.load_dc <= dc;
    tick(4);
    for (int c = 15; c >= 0; c--) begin
      for (int i = 15; i > (dc ? 9 : 3); i--) sclk(w[c][i]);
    end
    o_link.shift_clk    <= 1'b0;
    tick(4);
    o_link.latch_strobe <= 1'b1;
    tick(4);
    o_link.latch_strobe <= 1'b0;
    tick(4);
    o_link.load_dc      <= 1'b0;
    if (!dc) sclk(1'b0);
    o_link.shift_clk    <= 1'b0;
    tick(4);
  endtask : load
  task automatic gs_tick();
    o_link.grayscale_clock <= 1'b1;
    tick(4);
    o_link.grayscale_clock <= 1'b0;
    tick(4);
  endtask : gs_tick
  task automatic blank(input logic v);
    o_link.blank <= v;
    tick(6);
  endtask : blank
endmodule : lgsd_host

// ### verification/led_grayscale_serial_driver_tb.sv
/* self-checking bench: loads correction and grayscale, runs one frame
   assumes lgsd_host drives the six host pins of uut; i_clk and i_rst_n come from the bench */
`timescale 1ns/1ps
module led_grayscale_serial_driver_tb;
  import lgsd_pkg::*;
  logic        i_clk;
  logic        i_rst_n;
  lgsd_link_t  lk;
  logic [15:0] led;
  logic        sdo;
  int          mismatches;
  int          check_count;
  logic [15:0] gsw [16];
  logic [15:0] dcw [16];
  lgsd_host host (.i_clk(i_clk), .o_link(lk));
  lgsd_top uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_serial_data_in(lk.serial_data_in),
    .i_shift_clk(lk.shift_clk), .i_latch_strobe(lk.latch_strobe),
    .i_grayscale_clock(lk.grayscale_clock), .i_blank(lk.blank),
    .i_load_dc(lk.load_dc), .o_led(led), .o_serial_data_out(sdo));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    if (mismatches == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic after_reset();
    host.tick(2);
    check("rst", led, 16'h0000);
    check("rst_chain", {15'h0000, sdo}, 16'h0000);
  endtask : after_reset
  task automatic load_all();
    host.load(1'b1, dcw);
    host.load(1'b0, gsw);
    check("chain", {15'h0000, sdo}, {15'h0000, gsw[15][14]});
  endtask : load_all
  task automatic frame();
    logic [15:0] exp;
    int          on;
    host.blank(1'b1);
    host.gs_tick();
    check("blank", led, 16'h0000);
    host.blank(1'b0);
    for (int k = 0; k <= 4096; k++) begin
      for (int n = 0; n < 16; n++) begin
        on     = (int'(gsw[n][15:4]) * (int'(dcw[n][15:10]) + 1)) >> 6;
        exp[n] = (k < on);
      end
      check("led", led, exp);
      host.gs_tick();
    end
    host.blank(1'b1);
    check("reblank", led, 16'h0000);
  endtask : frame
  initial begin
    mismatches  = 0;
    check_count = 0;
    i_rst_n     = 1'b0;
    for (int n = 0; n < 16; n++) begin
      gsw[n] = {12'(n * 200), 4'h5};
      dcw[n] = {6'(63 - 4 * n), 2'b11, 8'h00};
    end
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    after_reset();
    load_all();
    frame();
    conclude();
  end
endmodule : led_grayscale_serial_driver_tb
